// [pkg/sar_readout_pkg.sv]
// Shared constants and types for the converter serial readout block
package sar_readout_pkg;
    localparam int MCLK_MHZ = 200;
    localparam int CONV_TIME_NS = 3000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * MCLK_MHZ + 999) / 1000;
    localparam int DATA_W = 16;
    localparam int EDGE_W = 4;
    localparam logic [4:0] EDGES_PLAIN = 5'h10;
    localparam logic [4:0] EDGES_BUSY = 5'h11;
    localparam logic [4:0] EDGE_SAT = 5'h1F;
    localparam logic [4:0] EDGE_ONE = 5'h01;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    typedef enum logic [1:0] {
        S_ACQ = 2'b00,
        S_CONV = 2'b01,
        S_READ = 2'b11
    } phase_e;

    typedef struct packed {
        logic chain;
        logic busy_en;
    } mode_s;

    typedef struct packed {
        logic [EDGE_W-1:0] gray;
        logic data_bit;
    } link_s;

    localparam mode_s MODE_RST = '{chain: 1'b0, busy_en: 1'b0};
    localparam link_s LINK_RST = '{gray: 4'h0, data_bit: 1'b0};
endpackage : sar_readout_pkg

// [hdl/fall_edge_tracker.sv]
// Serial clock domain: counts falling edges and captures the serial input
`timescale 1ns/100ps
module fall_edge_tracker
    import sar_readout_pkg::*;
(
    // Link clock and reset
    input wire logic sclk_i,
    input wire logic reset_i,
    // Upstream serial data
    input wire logic serial_in_i,
    // Toward the system clock domain
    output link_s link_o
);
    logic [EDGE_W-1:0] edge_bin;
    logic [EDGE_W-1:0] next_bin;

    assign next_bin = edge_bin + 1'b1;

    always_ff @(negedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_bin <= '0;
        end else begin
            edge_bin <= next_bin;
        end
    end

    // Gray count lets the other domain sample it safely while the clock runs
    always_ff @(negedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            link_o <= LINK_RST;
        end else begin
            link_o.gray <= next_bin ^ (next_bin >> 1);
            link_o.data_bit <= serial_in_i;
        end
    end
endmodule : fall_edge_tracker

// [hdl/sar_serial_readout.sv]
// Conversion control and serial readout of a 16-bit converter
// Summary of operation
// - Select start: rising start begins conversion, output off
// - Conversion always completes once started
// - Busy select: output driven low at completion
// - Busy select: MSB first, off after edge 17
// - Start and input both low drive output low
// - Plain select: input low reads, off after 16
// - Input low at start rise selects chain
// - Clock level at start rise selects chain busy
// - Chain mode drives the output always
// - Chain plain: MSB at completion, shift on falls
// - Chain: upstream bits shift in on falls
// - Chain busy: assert when done and upstream busy
// - Chain busy: first fall flushes busy bit only
// - Start fall with clock high sleeps, low wakes
`timescale 1ns/100ps
module sar_serial_readout
    import sar_readout_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES
) (
    // System clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Link pins
    input wire logic sclk_i,
    input wire logic convert_start_pin_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n_o,
    // Converter core
    input wire logic [DATA_W-1:0] sample_i,
    output logic sample_req_o,
    output logic shutdown_o
);
    localparam int CNT_W = $clog2(CONV_CNT + 1);
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CNT - 1);
    localparam int CONV_WAIT = CONV_CNT + 1;

    logic [1:0] cs_sync;
    logic [1:0] si_sync;
    logic [1:0] sck_sync;
    logic cs_s;
    logic si_s;
    logic sck_s;
    logic cs_d;
    logic si_d;
    logic cs_rise;
    logic cs_fall;
    link_s link_w;
    link_s link_m1;
    link_s link_m2;
    logic [EDGE_W-1:0] cnt_prev;
    logic fe_pulse;
    phase_e state;
    mode_s mode;
    logic [CNT_W-1:0] conv_cnt;
    logic [DATA_W-1:0] shreg;
    logic [4:0] edge_cnt;
    logic busy_phase;
    logic busy_seen;
    logic sel_done;
    logic start_ok;
    logic conv_done;
    logic busy_now;
    logic sel_active;
    logic shift_ok;
    logic [4:0] edge_limit;
    logic next_sdo;
    logic next_oe_n;
    logic shreg_msb;
    logic [DATA_W-2:0] shreg_low;
    logic link_bit;

    function automatic logic [EDGE_W-1:0] gray2bin(input logic [EDGE_W-1:0] g);
        logic [EDGE_W-1:0] b;
        b = '0;
        b[EDGE_W-1] = g[EDGE_W-1];
        for (int i = EDGE_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    fall_edge_tracker u_tracker (
        .sclk_i(sclk_i),
        .reset_i(reset_i),
        .serial_in_i(serial_in_pin_i),
        .link_o(link_w)
    );

    // Pin synchronisers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_sync <= 2'h0;
            si_sync <= 2'h0;
            sck_sync <= 2'h0;
            cs_d <= 1'b0;
            si_d <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], convert_start_pin_i};
            si_sync <= {si_sync[0], serial_in_pin_i};
            sck_sync <= {sck_sync[0], sclk_i};
            cs_d <= cs_s;
            si_d <= si_s;
        end
    end

    assign cs_s = cs_sync[1];
    assign si_s = si_sync[1];
    assign sck_s = sck_sync[1];
    assign cs_rise = cs_s & ~cs_d;
    assign cs_fall = ~cs_s & cs_d;

    // Edge count crossing; data bit is read one cycle after the step shows, past any skew
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            link_m1 <= LINK_RST;
            link_m2 <= LINK_RST;
            cnt_prev <= '0;
            fe_pulse <= 1'b0;
        end else begin
            link_m1 <= link_w;
            link_m2 <= link_m1;
            cnt_prev <= gray2bin(link_m2.gray);
            fe_pulse <= gray2bin(link_m2.gray) != cnt_prev;
        end
    end

    assign link_bit = link_m2.data_bit;
    assign start_ok = cs_rise && !shutdown_o && state != S_CONV;
    assign conv_done = state == S_CONV && conv_cnt == '0;
    assign busy_now = mode.chain ? mode.busy_en : (!cs_s || !si_s);
    assign sel_active = mode.busy_en || !cs_s || !si_s;
    assign shift_ok = fe_pulse && state == S_READ && (mode.chain || (sel_active && !sel_done));
    assign edge_limit = mode.busy_en ? EDGES_BUSY : EDGES_PLAIN;
    assign shreg_msb = shreg[DATA_W-1];
    assign shreg_low = shreg[DATA_W-2:0];

    // Phase and mode; the previous input level stands for the level just before the rise
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= S_ACQ;
            mode <= MODE_RST;
            conv_cnt <= '0;
            sample_req_o <= 1'b0;
        end else begin
            sample_req_o <= 1'b0;
            if (start_ok) begin
                state <= S_CONV;
                conv_cnt <= CONV_LOAD;
                sample_req_o <= 1'b1;
                mode.chain <= !si_d;
                mode.busy_en <= !si_d && sck_s;
            end else begin
                case (state)
                    S_CONV: begin
                        if (conv_cnt == '0) begin
                            state <= S_READ;
                            mode.busy_en <= busy_now;
                        end else begin
                            conv_cnt <= conv_cnt - 1'b1;
                        end
                    end
                    S_ACQ, S_READ: begin
                        state <= state;
                    end
                    default: begin
                        state <= S_ACQ;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            shutdown_o <= 1'b0;
        end else if (cs_fall) begin
            shutdown_o <= sck_s;
        end
    end

    // Result word, readout count and busy flags
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            shreg <= RESULT_RST;
            edge_cnt <= '0;
            busy_phase <= 1'b0;
            busy_seen <= 1'b0;
            sel_done <= 1'b1;
        end else if (conv_done) begin
            shreg <= sample_i;
            edge_cnt <= '0;
            busy_phase <= busy_now;
            busy_seen <= 1'b0;
            sel_done <= 1'b0;
        end else begin
            if (shift_ok) begin
                edge_cnt <= (edge_cnt == EDGE_SAT) ? edge_cnt : edge_cnt + EDGE_ONE;
                if (busy_phase) begin
                    busy_phase <= 1'b0;
                end else begin
                    shreg <= {shreg_low, mode.chain & link_bit};
                end
                if (!mode.chain && edge_cnt + EDGE_ONE == edge_limit) begin
                    sel_done <= 1'b1;
                end
            end
            if (cs_rise && !mode.chain) begin
                sel_done <= 1'b1;
            end
            if (state == S_READ && mode.chain && si_s) begin
                busy_seen <= 1'b1;
            end
        end
    end

    // Output pin; a chain stays driven so downstream parts never see a floating input
    always_comb begin
        next_sdo = 1'b0;
        next_oe_n = 1'b1;
        if (mode.chain) begin
            next_oe_n = 1'b0;
            if (state == S_READ) begin
                next_sdo = busy_phase ? busy_seen : shreg_msb;
            end
        end else if (state == S_READ && !sel_done && sel_active) begin
            next_oe_n = 1'b0;
            next_sdo = busy_phase ? 1'b0 : shreg_msb;
        end
        if (!cs_s && !si_s) begin
            next_oe_n = 1'b0;
            next_sdo = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_n_o <= 1'b1;
        end else begin
            serial_out_pin_o <= next_sdo;
            serial_out_pin_oe_n_o <= next_oe_n;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_sel_start;
        start_ok && si_d ##1 cs_s;
    endsequence
    sequence s_sel_busy_done;
        conv_done && !mode.chain && (!cs_s || !si_s);
    endsequence
    sequence s_last_edge(logic [4:0] lim, logic busy);
        shift_ok && !mode.chain && mode.busy_en == busy && edge_cnt + EDGE_ONE == lim ##1 (cs_s || si_s);
    endsequence

    property p_start_hiz;
        s_sel_start |=> serial_out_pin_oe_n_o && state == S_CONV;
    endproperty
    a_start_hiz: assert property (p_start_hiz) else $error("output not released at start");
    property p_conv_run;
        state == S_CONV && $past(state) != S_CONV |-> ##[1:CONV_WAIT] state == S_READ;
    endproperty
    a_conv_run: assert property (p_conv_run) else $error("conversion did not complete in time");
    property p_busy_low;
        s_sel_busy_done |=> ##1 !serial_out_pin_oe_n_o && !serial_out_pin_o;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy indication not driven low");
    property p_busy_end;
        s_last_edge(EDGES_BUSY, 1'b1) |=> serial_out_pin_oe_n_o;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("output still driven after edge 17");
    property p_both_low;
        !cs_s && !si_s |=> !serial_out_pin_oe_n_o && !serial_out_pin_o;
    endproperty
    a_both_low: assert property (p_both_low) else $error("output not low with both pins low");
    property p_plain_end;
        s_last_edge(EDGES_PLAIN, 1'b0) |=> serial_out_pin_oe_n_o;
    endproperty
    a_plain_end: assert property (p_plain_end) else $error("output still driven after edge 16");
    property p_mode_sel;
        start_ok |=> mode.chain != $past(si_d);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("wrong mode latched");
    property p_chain_busy;
        start_ok && !si_d |=> mode.busy_en == $past(sck_s);
    endproperty
    a_chain_busy: assert property (p_chain_busy) else $error("chain busy option not latched");
    property p_chain_drive;
        mode.chain && $past(mode.chain) |-> !serial_out_pin_oe_n_o;
    endproperty
    a_chain_drive: assert property (p_chain_drive) else $error("chain output released");
    property p_chain_msb;
        conv_done && mode.chain && !busy_now |=> shreg == $past(sample_i) ##1 serial_out_pin_o == $past(shreg_msb);
    endproperty
    a_chain_msb: assert property (p_chain_msb) else $error("chain MSB not presented");
    property p_chain_shift;
        shift_ok && mode.chain && !busy_phase && !conv_done |=> shreg == {$past(shreg_low), $past(link_bit)};
    endproperty
    a_chain_shift: assert property (p_chain_shift) else $error("chain shift wrong");
    property p_chain_wait;
        state == S_READ && mode.chain && busy_phase && !busy_seen |=> !serial_out_pin_o;
    endproperty
    a_chain_wait: assert property (p_chain_wait) else $error("busy shown before upstream ready");
    property p_flush;
        shift_ok && mode.chain && busy_phase |=> !busy_phase && $stable(shreg);
    endproperty
    a_flush: assert property (p_flush) else $error("busy flush edge shifted data");
    property p_sleep;
        cs_fall |=> shutdown_o == $past(sck_s);
    endproperty
    a_sleep: assert property (p_sleep) else $error("shutdown state wrong");
endmodule : sar_serial_readout

// [test/sar_host_model.sv]
// Host controller model that drives the converter link pins
`timescale 1ns/100ps
module sar_host_model (
    // System clock used to place pin changes
    input wire logic mclk_i,
    // Link pins toward the converter
    output logic sclk_o,
    output logic convert_start_o,
    output logic serial_in_o
);
    initial begin
        sclk_o = 1'b0;
        convert_start_o = 1'b0;
        serial_in_o = 1'b1;
    end

    // Levels held until the next call, so start stays put through conversion and readback; fall_once also drives the clock and input
    task automatic set_pins(input logic cnv, input logic serial_in_pin, input logic sck);
        @(negedge mclk_i);
        convert_start_o <= cnv;
        serial_in_o <= serial_in_pin;
        sclk_o <= sck;
    endtask : set_pins

    // One link clock period of 125 ns; the offset keeps it out of phase with the system clock
    task automatic fall_once(input logic serial_in_pin);
        #1.3;
        sclk_o = 1'b1;
        serial_in_o = serial_in_pin;
        #62.5;
        sclk_o = 1'b0;
        #61.2;
    endtask : fall_once
endmodule : sar_host_model

// [test/sar_serial_readout_tb_top.sv]
// Self-checking bench for the converter serial readout block
`timescale 1ns/100ps
module sar_serial_readout_tb_top;
    import sar_readout_pkg::*;
    localparam int CONV_SMALL = 8;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [DATA_W-1:0] sample_i = 16'h0000;
    logic sclk, cnv, serial_in_pin, sdo_raw, oe_n, req, shut;
    int error_cnt = 0;
    int samples_checked = 0;
    int req_cnt = 0;
    // Pull-up holds the data line high whenever the block releases it
    wire sdo_w = oe_n ? 1'b1 : sdo_raw;

    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (req === 1'b1) req_cnt <= req_cnt + 1;

    sar_host_model host_u (.mclk_i(mclk_i), .sclk_o(sclk), .convert_start_o(cnv), .serial_in_o(serial_in_pin));
    sar_serial_readout #(.CONV_CNT(CONV_SMALL)) dut_u (
        .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk), .convert_start_pin_i(cnv),
        .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(sdo_raw), .serial_out_pin_oe_n_o(oe_n),
        .sample_i(sample_i), .sample_req_o(req), .shutdown_o(shut));

    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wait_cyc

    // Bounded wait: a conversion that never ends must not hang the run
    task automatic wait_oe(input logic exp);
        int n = 0;
        while (oe_n !== exp && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        if (oe_n !== exp) begin
            error_cnt++;
            $display("[ERR] oe_n expected %b seen %b", exp, oe_n);
            final_report();
        end
    endtask : wait_oe

    task automatic shift_out(input logic [31:0] exp, input int n, input logic [31:0] up);
        for (int k = 0; k < n; k++) begin
            host_u.fall_once(up[31-k]);
            chk("serial_out", exp[31-k], sdo_w);
            chk("oe_n", 1'b0, oe_n);
        end
    endtask : shift_out

    task automatic t_select_plain(input logic [15:0] w);
        int r0;
        sample_i = w;
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(6);
        r0 = req_cnt;
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(8);
        chk("start_req", 1'b1, req_cnt == r0 + 1);
        chk("oe_n", 1'b1, oe_n);
        wait_cyc(40);
        chk("oe_n", 1'b1, oe_n);
        host_u.set_pins(1'b1, 1'b0, 1'b0);
        wait_cyc(8);
        chk("serial_out", w[15], sdo_w);
        shift_out({w[14:0], 17'h0_0000}, 15, 32'h0000_0000);
        host_u.fall_once(1'b0);
        chk("oe_n", 1'b1, oe_n);
        host_u.set_pins(1'b1, 1'b1, 1'b0);
    endtask : t_select_plain

    task automatic t_select_busy(input logic [15:0] w);
        sample_i = w;
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(6);
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(4);
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(1);
        chk("oe_n", 1'b1, oe_n);
        wait_oe(1'b0);
        chk("serial_out", 1'b0, sdo_w);
        shift_out({w, 16'h0000}, 16, 32'hFFFF_FFFF);
        host_u.fall_once(1'b1);
        chk("oe_n", 1'b1, oe_n);
    endtask : t_select_busy

    // Four-wire busy: start stays high, the input goes low during conversion
    task automatic t_select_busy4(input logic [15:0] w);
        sample_i = w;
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(6);
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(4);
        host_u.set_pins(1'b1, 1'b0, 1'b0);
        wait_cyc(1);
        chk("oe_n", 1'b1, oe_n);
        wait_oe(1'b0);
        chk("serial_out", 1'b0, sdo_w);
        shift_out({w, 16'h0000}, 16, 32'h0000_0000);
        host_u.fall_once(1'b0);
        chk("oe_n", 1'b1, oe_n);
    endtask : t_select_busy4

    task automatic t_chain_plain(input logic [15:0] w, input logic [15:0] u);
        sample_i = w;
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        wait_cyc(6);
        chk("oe_n", 1'b0, oe_n);
        chk("serial_out", 1'b0, sdo_w);
        host_u.set_pins(1'b1, 1'b0, 1'b0);
        wait_cyc(8);
        chk("oe_n", 1'b0, oe_n);
        wait_cyc(40);
        chk("serial_out", w[15], sdo_w);
        shift_out({w[14:0], u, 1'b0}, 31, {u, 16'h0000});
    endtask : t_chain_plain

    // Input tied to start: both pins rise together, the level just before the rise picks chain
    task automatic t_chain_tied(input logic [15:0] w);
        sample_i = w;
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        wait_cyc(6);
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(8);
        chk("oe_n", 1'b0, oe_n);
        wait_cyc(40);
        chk("serial_out", w[15], sdo_w);
        shift_out({w[14:0], 17'h1_FFFF}, 16, 32'hFFFF_FFFF);
    endtask : t_chain_tied

    task automatic t_chain_busy(input logic [15:0] w);
        sample_i = w;
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        host_u.set_pins(1'b0, 1'b0, 1'b1);
        wait_cyc(6);
        host_u.set_pins(1'b1, 1'b0, 1'b1);
        wait_cyc(48);
        chk("serial_out", 1'b0, sdo_w);
        host_u.set_pins(1'b1, 1'b1, 1'b1);
        wait_cyc(8);
        chk("serial_out", 1'b1, sdo_w);
        shift_out({w, 16'h0000}, 16, 32'hFFFF_FFFF);
    endtask : t_chain_busy

    task automatic t_shutdown();
        int r0;
        host_u.set_pins(1'b1, 1'b1, 1'b1);
        wait_cyc(6);
        host_u.set_pins(1'b0, 1'b1, 1'b1);
        wait_cyc(6);
        chk("shutdown", 1'b1, shut);
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(6);
        r0 = req_cnt;
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(20);
        chk("start_req", 1'b1, req_cnt == r0);
        host_u.set_pins(1'b0, 1'b1, 1'b0);
        wait_cyc(6);
        chk("shutdown", 1'b0, shut);
    endtask : t_shutdown

    initial begin
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        wait_cyc(4);
        t_select_plain(16'hA5C3);
        t_select_busy(16'h8001);
        t_select_busy4(16'h7FFE);
        t_chain_plain(16'hB4E1, 16'h7E18);
        t_chain_tied(16'h5A3C);
        t_chain_busy(16'hFFFE);
        t_shutdown();
        t_select_plain(16'h0FF0);
        final_report();
    end
endmodule : sar_serial_readout_tb_top
